/* File: hw/fsg_cfg.svh */
`ifndef FSG_CFG_SVH
`define FSG_CFG_SVH
// ****************************************
// register map
// ****************************************
`define FSG_REG_CFG 4'h0
`define FSG_REG_STAT 4'h4
`define FSG_CFG_COLL 0
`define FSG_CFG_LEN_LSB 8
`define FSG_STAT_TX_LSB 16
// ****************************************
// process image fields
// ****************************************
`define FSG_C0_CMD 0
`define FSG_C0_BCAST 1
`define FSG_C0_ND 7
`define FSG_C1_RACK 0
`define FSG_C1_SFB 2
`define FSG_C1_CTB 3
`define FSG_S0_BLR 1
`define FSG_S0_DEX 3
`define FSG_CB_VER 0
`define FSG_CB_GATE 1
// ****************************************
// characters and patterns
// ****************************************
`define FSG_RST_PAT 8'haa
`define FSG_CH_STX 8'h02
`define FSG_CH_CR 8'h0d
`define FSG_CH_LF 8'h0a
`define FSG_CH_PLUS 8'h2b
`define FSG_CH_MINUS 8'h2d
`define FSG_CH_VER 8'h76
`define FSG_CH_ZERO 8'h30
`define FSG_CH_B 8'h42
`define FSG_CH_SPACE 8'h20
`define FSG_CH_DEL 8'h7f
// ****************************************
// timing and sizes
// ****************************************
`define FSG_CLK_KHZ 10000
`define FSG_HOLD_MS 20
`define FSG_GAP_MS 20
`define FSG_BUF_BYTES 1024
`endif

/* File: hw/fsg_gateway.sv */
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "fsg_cfg.svh"
// Overview of operation
// - AAh pattern over 20 ms clears buffers, image and sequencers; config register keeps its value
// - transparent or collective mode, transparent first
// - transparent passes rx directly, excess dropped
// - strip control characters, zero ends telegram
// - collective buffers rx, raises data available
// - collective buffer holds one kilobyte
// - output without copy or send toggle goes straight out
// - next block only on acknowledge toggle
// - copy toggle appends payload to tx buffer
// - send toggle drains tx buffer in order
// - command mode blocks forwarding of output data
// - rx path unaffected by command mode
// - command bits send framed one-character commands
// - replies reach controller without delay in transparent mode
// - control byte bit layout
// - broadcast bit prefixes broadcast command
// - acknowledge change copies block, toggles ready; with the buffer empty it only clears the image
module fsg_gateway
   import fsg_pkg::*;
#(
   parameter int OUT_BYTES = 4,
   parameter int IN_BYTES = 8,
   parameter int BUF_DEPTH = `FSG_BUF_BYTES,
   parameter int HOLD_CYC = `FSG_HOLD_MS * `FSG_CLK_KHZ,
   parameter int GAP_CYC = `FSG_GAP_MS * `FSG_CLK_KHZ
) (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   input wire logic pd_valid_i,
   input wire logic [8*OUT_BYTES-1:0] pd_out_i,
   output logic [8*IN_BYTES-1:0] pd_in_o,
   input wire logic rx_valid_i,
   input wire logic [7:0] rx_data_i,
   output logic tx_valid_o,
   output logic [7:0] tx_data_o,
   input wire logic tx_ready_i
);
   localparam int OD = OUT_BYTES - 2;
   localparam int ID = IN_BYTES - 2;
   localparam int AW = $clog2(BUF_DEPTH);
   localparam int CW = $clog2(HOLD_CYC + 2);
   localparam int GW = $clog2(GAP_CYC + 1);
   localparam int IW = $clog2(IN_BYTES);
   localparam int CP_MAX = IN_BYTES;
   localparam int AP_MAX = 256;

   if (OUT_BYTES < 4 || OUT_BYTES > 255 || IN_BYTES < 3 || IN_BYTES > 255 ||
       AW > 15 || (1 << AW) != BUF_DEPTH) begin : g_chk
      $error("fsg_gateway: unsupported parameter values");
   end

   function automatic logic [7:0] fsg_byte(input logic [8*OD-1:0] v, input logic [7:0] i);
      return v[8*i +: 8];
   endfunction : fsg_byte

   // ****************************************
   // process image decode
   // ****************************************
   logic [7:0] ctl0, ctl1, cb, prev_ctl1, prev_cb, tgl, cb_rise, cb_chg;
   logic [8*OD-1:0] pay, prev_pay;
   logic prev_nd, pat, clr, pd, cmd_mode, idle, coll;
   logic cmd_go, ctb_go, sfb_go, dir_go;
   logic [7:0] cmd_char, tel_len;
   logic [CW-1:0] hold_cnt;
   fsg_tx_st_t st;
   fsg_src_t src;
   logic ap_active;
   logic [AW:0] rx_cnt, tx_cnt;

   assign ctl0 = pd_out_i[7:0];
   assign ctl1 = pd_out_i[15:8];
   assign pay = pd_out_i[8*OUT_BYTES-1:16];
   assign cb = pay[7:0];
   assign cmd_mode = ctl0[`FSG_C0_CMD];
   assign tgl = ctl1 ^ prev_ctl1;
   assign cb_rise = cb & ~prev_cb;
   assign cb_chg = cb ^ prev_cb;
   assign pat = ctl0 == `FSG_RST_PAT && ctl1 == `FSG_RST_PAT &&
                pay[7:0] == `FSG_RST_PAT && pay[15:8] == `FSG_RST_PAT;
   assign clr = pat && hold_cnt == CW'(HOLD_CYC);
   assign pd = pd_valid_i && !pat;
   assign idle = st == FSG_TX_IDLE && !ap_active;
   assign cmd_go = pd && cmd_mode && idle && (cb_rise[`FSG_CB_VER] || cb_chg[`FSG_CB_GATE]);
   assign cmd_char = cb_rise[`FSG_CB_VER] ? `FSG_CH_VER :
                     cb[`FSG_CB_GATE] ? `FSG_CH_PLUS : `FSG_CH_MINUS;
   assign ctb_go = pd && coll && !cmd_mode && tgl[`FSG_C1_CTB] && idle;
   assign sfb_go = pd && coll && !cmd_mode && tgl[`FSG_C1_SFB] && !tgl[`FSG_C1_CTB] &&
                   idle && tx_cnt != '0;
   assign dir_go = pd && !cmd_mode && !tgl[`FSG_C1_CTB] && !tgl[`FSG_C1_SFB] && idle &&
                   (pay != prev_pay || ctl0[`FSG_C0_ND] != prev_nd);

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         prev_ctl1 <= 8'h00;
         prev_cb <= 8'h00;
         prev_pay <= '0;
         prev_nd <= 1'b0;
      end else if (pd_valid_i || clr) begin
         prev_ctl1 <= ctl1;
         prev_cb <= cb;
         prev_pay <= pay;
         prev_nd <= ctl0[`FSG_C0_ND];
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!nrst_i || !pat) hold_cnt <= '0;
      else if (hold_cnt != CW'(HOLD_CYC + 1)) hold_cnt <= hold_cnt + CW'(1);
   end

   // ****************************************
   // software registers
   // ****************************************
   logic [31:0] rd_cfg, rd_stat;
   assign rd_cfg = 32'(coll) | (32'(tel_len) << `FSG_CFG_LEN_LSB);
   assign rd_stat = 32'(rx_cnt) | (32'(tx_cnt) << `FSG_STAT_TX_LSB);

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         coll <= 1'b0;
         tel_len <= 8'(OD);
      end else if (reg_wr_i && reg_addr_i == `FSG_REG_CFG) begin
         coll <= reg_wdata_i[`FSG_CFG_COLL];
         if (reg_wdata_i[15:8] != 8'h00 && reg_wdata_i[15:8] <= 8'(OD))
            tel_len <= reg_wdata_i[15:8];
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!nrst_i || !reg_rd_i) reg_rdata_o <= 32'h0000_0000;
      else if (reg_addr_i == `FSG_REG_CFG) reg_rdata_o <= rd_cfg;
      else if (reg_addr_i == `FSG_REG_STAT) reg_rdata_o <= rd_stat;
      else reg_rdata_o <= 32'h0000_0000;
   end

   // ****************************************
   // receive path into input image
   // ****************************************
   logic [7:0] rx_mem [BUF_DEPTH];
   logic [7:0] img [ID];
   logic [AW-1:0] rwp, rrp;
   logic [GW-1:0] gap_cnt;
   logic [IW-1:0] t_idx, t_idx_eff, cp_idx, cp_len, cp_n, img_wa;
   logic [7:0] vcnt, img_wd;
   logic t_end, t_new, t_ok, t_we, rx_push, cp_go, fin_go, cp_active, cp_done;
   logic img_clr, img_we, rx_data_available, block_ready_toggle;

   assign t_new = !coll && rx_valid_i && gap_cnt == GW'(GAP_CYC);
   assign t_ok = rx_data_i >= `FSG_CH_SPACE && rx_data_i != `FSG_CH_DEL;
   assign t_idx_eff = t_new ? '0 : t_idx;
   assign t_we = !coll && rx_valid_i && !(t_end && !t_new) && t_ok &&
                 t_idx_eff < IW'(ID) && !clr;
   assign rx_push = coll && rx_valid_i && rx_cnt != (AW+1)'(BUF_DEPTH) && !clr;
   function automatic logic rack_ev(input logic v, input logic m, input logic [7:0] t);
      return v && m && t[`FSG_C1_RACK];
   endfunction : rack_ev

   assign cp_go = rack_ev(pd, coll, tgl) && !cp_active && rx_cnt != '0;
   assign fin_go = rack_ev(pd, coll, tgl) && !cp_active && rx_cnt == '0;
   assign cp_n = rx_cnt > (AW+1)'(ID) ? IW'(ID) : IW'(rx_cnt);
   assign cp_done = cp_active && cp_idx == cp_len - IW'(1);
   assign img_clr = clr || fin_go || cp_go || t_new;
   assign img_we = (t_we || cp_active) && !clr;
   assign img_wa = cp_active ? cp_idx : t_idx_eff;
   assign img_wd = cp_active ? rx_mem[rrp] : rx_data_i;

   always_ff @(posedge mclk_i) begin
      if (rx_push) rx_mem[rwp] <= rx_data_i;
   end

   always_ff @(posedge mclk_i) begin
      for (int k = 0; k < ID; k++) begin
         if (!nrst_i || img_clr) img[k] <= 8'h00;
      end
      if (nrst_i && img_we) img[img_wa] <= img_wd;
   end

   always_ff @(posedge mclk_i) begin
      if (!nrst_i || rx_valid_i) gap_cnt <= nrst_i ? '0 : GW'(GAP_CYC);
      else if (gap_cnt != GW'(GAP_CYC)) gap_cnt <= gap_cnt + GW'(1);
   end

   always_ff @(posedge mclk_i) begin
      if (!nrst_i || clr) begin
         t_idx <= '0;
         t_end <= 1'b0;
      end else if (!coll && rx_valid_i) begin
         t_idx <= t_we ? t_idx_eff + IW'(1) : t_idx_eff;
         t_end <= (t_end && !t_new) || rx_data_i == 8'h00;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!nrst_i || clr) begin
         rwp <= '0;
         rrp <= '0;
         rx_cnt <= '0;
      end else begin
         rwp <= rwp + AW'(rx_push);
         rrp <= rrp + AW'(cp_active);
         rx_cnt <= rx_cnt + (AW+1)'(rx_push) - (AW+1)'(cp_active);
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!nrst_i || clr) begin
         cp_active <= 1'b0;
         cp_idx <= '0;
         cp_len <= '0;
         block_ready_toggle <= 1'b0;
      end else if (cp_go) begin
         cp_active <= 1'b1;
         cp_idx <= '0;
         cp_len <= cp_n;
      end else if (cp_active) begin
         cp_idx <= cp_idx + IW'(1);
         cp_active <= !cp_done;
         block_ready_toggle <= block_ready_toggle ^ cp_done;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!nrst_i || clr) vcnt <= 8'h00;
      else if (t_we) vcnt <= 8'(t_idx_eff) + 8'h01;
      else if (img_clr) vcnt <= 8'h00;
      else if (cp_done) vcnt <= 8'(cp_len);
   end

   always_ff @(posedge mclk_i) begin
      if (!nrst_i || clr) rx_data_available <= 1'b0;
      else rx_data_available <= rx_cnt != '0;
   end

   for (genvar g = 0; g < ID; g++) begin : g_img
      assign pd_in_o[8*(g+2) +: 8] = img[g];
   end
   assign pd_in_o[15:0] = {vcnt, 8'(rx_data_available) << `FSG_S0_DEX | 8'(block_ready_toggle) << `FSG_S0_BLR};

   // ****************************************
   // transmit buffer and serial sequencer
   // ****************************************
   logic [7:0] tx_mem [BUF_DEPTH];
   logic [AW-1:0] twp, trp;
   logic [7:0] ap_idx, tx_idx, cmd_q, nb, cmd_b;
   logic [8*OD-1:0] pay_q;
   logic tx_push, tx_pop, load, body_last;

   assign tx_push = ap_active && tx_cnt != (AW+1)'(BUF_DEPTH);
   assign load = st != FSG_TX_IDLE && (!tx_valid_o || tx_ready_i);
   assign tx_pop = load && st == FSG_TX_BODY && src == FSG_SRC_BUF;
   assign body_last = src == FSG_SRC_BUF ? tx_cnt == (AW+1)'(1) : tx_idx == tel_len - 8'h01;
   assign cmd_b = tx_idx == 8'h00 ? `FSG_CH_STX : tx_idx == 8'h01 ? cmd_q :
                  tx_idx == 8'h02 ? `FSG_CH_CR : `FSG_CH_LF;
   assign nb = st == FSG_TX_PREFIX ? (tx_idx == 8'h02 ? `FSG_CH_B : `FSG_CH_ZERO) :
               st == FSG_TX_CMD ? cmd_b :
               src == FSG_SRC_BUF ? tx_mem[trp] : fsg_byte(pay_q, tx_idx);

   always_ff @(posedge mclk_i) begin
      if (tx_push) tx_mem[twp] <= fsg_byte(pay, ap_idx);
   end

   always_ff @(posedge mclk_i) begin
      if (!nrst_i || clr) begin
         ap_active <= 1'b0;
         ap_idx <= 8'h00;
      end else if (ctb_go) begin
         ap_active <= 1'b1;
         ap_idx <= 8'h00;
      end else if (ap_active) begin
         ap_idx <= ap_idx + 8'h01;
         ap_active <= ap_idx != tel_len - 8'h01;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!nrst_i || clr) begin
         twp <= '0;
         trp <= '0;
         tx_cnt <= '0;
      end else begin
         twp <= twp + AW'(tx_push);
         trp <= trp + AW'(tx_pop);
         tx_cnt <= tx_cnt + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!nrst_i || clr) begin
         st <= FSG_TX_IDLE;
         src <= FSG_SRC_DIR;
         tx_idx <= 8'h00;
         cmd_q <= 8'h00;
         pay_q <= '0;
      end else if (cmd_go) begin
         st <= FSG_TX_CMD;
         tx_idx <= 8'h00;
         cmd_q <= cmd_char;
      end else if (sfb_go || dir_go) begin
         st <= ctl0[`FSG_C0_BCAST] ? FSG_TX_PREFIX : FSG_TX_BODY;
         src <= sfb_go ? FSG_SRC_BUF : FSG_SRC_DIR;
         tx_idx <= 8'h00;
         pay_q <= pay;
      end else if (load) begin
         tx_idx <= tx_idx + 8'h01;
         case (st)
            FSG_TX_PREFIX: begin
               if (tx_idx == 8'h02) begin
                  st <= FSG_TX_BODY;
                  tx_idx <= 8'h00;
               end
            end
            FSG_TX_BODY: if (body_last) st <= FSG_TX_IDLE;
            FSG_TX_CMD: if (tx_idx == 8'h03) st <= FSG_TX_IDLE;
            default: st <= FSG_TX_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         tx_valid_o <= 1'b0;
         tx_data_o <= 8'h00;
      end else if (load) begin
         tx_valid_o <= 1'b1;
         tx_data_o <= nb;
      end else if (tx_ready_i) begin
         tx_valid_o <= 1'b0;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb_chk @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);

   sequence s_frame_head;
      tx_valid_o && tx_data_o == `FSG_CH_STX;
   endsequence
   sequence s_append_done;
      !ap_active && tx_cnt == (AW+1)'(tel_len);
   endsequence

   chk_pattern_clear: assert property (clr |=> rx_cnt == '0 && tx_cnt == '0 && !block_ready_toggle && vcnt == 8'h00)
      else $error("reset pattern did not clear state");
   chk_start_mode: assert property ($rose(nrst_i) |-> !coll)
      else $error("not transparent after reset");
   chk_trans_cut: assert property (!coll && rx_valid_i && rx_data_i == 8'h00 && !clr |=> t_end)
      else $error("zero byte did not end telegram");
   chk_trans_drop: assert property (!coll && rx_valid_i && !t_new && !clr && t_idx == IW'(ID) |=> vcnt == 8'(ID))
      else $error("excess transparent byte not dropped");
   chk_dex_raise: assert property (rx_push && !cp_active ##1 !clr |=> rx_data_available)
      else $error("data available not raised");
   chk_block_ready: assert property (cp_go |-> ##[2:CP_MAX] (block_ready_toggle != $past(block_ready_toggle)))
      else $error("block ready did not toggle");
   chk_cmd_head: assert property (cmd_go && !tx_valid_o |-> ##2 s_frame_head)
      else $error("command frame does not start with start char");
   chk_cmd_silent: assert property (st == FSG_TX_IDLE && cmd_mode && !clr |=> st != FSG_TX_BODY)
      else $error("output data forwarded in command mode");
   chk_buf_drained: assert property (tx_pop && tx_cnt == (AW+1)'(1) && !tx_push && !clr |=> st == FSG_TX_IDLE && tx_cnt == '0)
      else $error("send from buffer left data or busy");
   chk_ctb_append: assert property (ctb_go && tx_cnt == '0 && !clr ##1 !clr [*3] |-> ##[1:AP_MAX] s_append_done)
      else $error("copy toggle did not append payload");
endmodule : fsg_gateway
`default_nettype wire

/* File: hw/fsg_pkg.sv */
package fsg_pkg;
   typedef enum logic [1:0] {
      FSG_TX_IDLE = 2'b00,
      FSG_TX_PREFIX = 2'b01,
      FSG_TX_BODY = 2'b10,
      FSG_TX_CMD = 2'b11
   } fsg_tx_st_t;
   typedef enum logic {
      FSG_SRC_DIR = 1'b0,
      FSG_SRC_BUF = 1'b1
   } fsg_src_t;
endpackage : fsg_pkg

/* File: verif/fsg_serial_sink.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// serial end device, receive side
// ****************************************
module fsg_serial_sink
   import fsg_pkg::*;
(
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic stall_i,
   input wire logic tx_valid_i,
   input wire logic [7:0] tx_data_i,
   output logic tx_ready_o
);
   logic [1:0] phase;
   logic [7:0] got[$];
   // ready one cycle in four while stalling
   always @(posedge mclk_i) begin
      if (!nrst_i) begin
         phase <= 2'h0;
         tx_ready_o <= 1'b0;
      end else begin
         phase <= phase + 2'h1;
         tx_ready_o <= !stall_i || (phase == 2'h3);
         if (tx_valid_i && tx_ready_o) begin
            got.push_back(tx_data_i);
         end
      end
   end
endmodule : fsg_serial_sink
`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fsg_cfg.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end
// ****************************************
// gateway bench
// ****************************************
module tb_top
   import fsg_pkg::*;
;
   localparam int HOLD = 50;
   localparam int GAP = 20;
   logic mclk_i, nrst_i, reg_wr_i, reg_rd_i, pd_valid_i, rx_valid_i, stall, tx_valid_o, tx_ready;
   logic [3:0] reg_addr_i;
   logic [31:0] reg_wdata_i, reg_rdata_o;
   logic [31:0] pd_out_i;
   logic [63:0] pd_in_o;
   logic [7:0] rx_data_i, tx_data_o;
   logic [7:0] exp[$];
   int n_errors = 0;
   int n_compared = 0;
   fsg_gateway #(.OUT_BYTES(4), .IN_BYTES(8), .HOLD_CYC(HOLD), .GAP_CYC(GAP)) u_fsg_gateway (
      .mclk_i(mclk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .pd_valid_i(pd_valid_i), .pd_out_i(pd_out_i), .pd_in_o(pd_in_o),
      .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .tx_valid_o(tx_valid_o),
      .tx_data_o(tx_data_o), .tx_ready_i(tx_ready));
   fsg_serial_sink u_fsg_serial_sink (.mclk_i(mclk_i), .nrst_i(nrst_i), .stall_i(stall),
      .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .tx_ready_o(tx_ready));
   initial begin
      mclk_i = 1'b0;
      forever #50 mclk_i = ~mclk_i;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_i);
   endtask : cyc
   task automatic end_of_test();
      if (n_errors == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_of_test
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge mclk_i);
      reg_wr_i <= 1'b0;
   endtask : wr
   task automatic chk_rd(input logic [3:0] a, input logic [31:0] e, input string nm);
      @(posedge mclk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge mclk_i);
      reg_rd_i <= 1'b0;
      #1;
      `CHK(nm, e, reg_rdata_o)
   endtask : chk_rd
   task automatic pd(input logic [7:0] c0, c1, d0, d1);
      @(posedge mclk_i);
      pd_out_i <= {d1, d0, c1, c0};
      pd_valid_i <= 1'b1;
      @(posedge mclk_i);
      pd_valid_i <= 1'b0;
   endtask : pd
   task automatic rx(input logic [7:0] b);
      @(posedge mclk_i);
      rx_valid_i <= 1'b1;
      rx_data_i <= b;
      @(posedge mclk_i);
      rx_valid_i <= 1'b0;
   endtask : rx
   task automatic chk_tx(input string nm);
      int i;
      i = 0;
      while (u_fsg_serial_sink.got.size() < exp.size() && i < 300) begin
         @(posedge mclk_i);
         i++;
      end
      cyc(10);
      `CHK(nm, exp.size(), u_fsg_serial_sink.got.size())
      for (int k = 0; k < exp.size() && k < u_fsg_serial_sink.got.size(); k++) begin
         `CHK(nm, exp[k], u_fsg_serial_sink.got[k])
      end
      u_fsg_serial_sink.got.delete();
      exp.delete();
   endtask : chk_tx
   initial begin
      cyc(20000);
      n_errors++;
      end_of_test();
   end
   initial begin
      nrst_i = 1'b0;
      {reg_wr_i, reg_rd_i, pd_valid_i, rx_valid_i, stall} = 5'h0;
      reg_addr_i = 4'h0;
      reg_wdata_i = 32'h0;
      pd_out_i = 32'h0;
      rx_data_i = 8'h0;
      cyc(3);
      nrst_i <= 1'b1;
      `CHK("image reset", 64'h0, pd_in_o)
      `CHK("tx reset", 1'b0, tx_valid_o)
      chk_rd(`FSG_REG_CFG, 32'h0000_0200, "cfg reset");
      chk_rd(4'h8, 32'h0, "unmapped");
      cyc(GAP + 2);
      foreach (exp[k]) exp[k] = 8'h0;
      rx(8'h41);
      rx(8'h01);
      rx(8'h42);
      rx(8'h00);
      rx(8'h43);
      cyc(2);
      `CHK("strip", 64'h00000000_42410200, pd_in_o)
      cyc(GAP + 2);
      for (int k = 0; k < 7; k++) rx(8'h31 + 8'(k));
      cyc(2);
      `CHK("overflow", 64'h36353433_32310600, pd_in_o)
      stall <= 1'b1;
      pd(8'h00, 8'h00, 8'h31, 8'h32);
      exp = '{8'h31, 8'h32};
      chk_tx("direct");
      pd(8'h80, 8'h00, 8'h31, 8'h32);
      exp = '{8'h31, 8'h32};
      chk_tx("resend");
      pd(8'h82, 8'h00, 8'h34, 8'h36);
      exp = '{8'h30, 8'h30, 8'h42, 8'h34, 8'h36};
      chk_tx("broadcast");
      pd(8'h01, 8'h00, 8'h01, 8'h00);
      exp = '{8'h02, 8'h76, 8'h0d, 8'h0a};
      chk_tx("cmd v");
      pd(8'h01, 8'h00, 8'h03, 8'h00);
      exp = '{8'h02, 8'h2b, 8'h0d, 8'h0a};
      chk_tx("cmd plus");
      pd(8'h01, 8'h00, 8'h01, 8'h00);
      exp = '{8'h02, 8'h2d, 8'h0d, 8'h0a};
      chk_tx("cmd minus");
      pd(8'h01, 8'h00, 8'h01, 8'h55);
      chk_tx("cmd blocks");
      cyc(GAP + 2);
      rx(8'h5a);
      cyc(2);
      `CHK("cmd rx", 64'h00000000_005a0100, pd_in_o)
      pd(8'h00, 8'h00, 8'h01, 8'h55);
      chk_tx("no change");
      wr(`FSG_REG_CFG, 32'h0000_0201);
      wr(`FSG_REG_CFG, 32'h0000_0501);
      wr(4'h8, 32'h0);
      chk_rd(`FSG_REG_CFG, 32'h0000_0201, "cfg coll");
      pd(8'h00, 8'h08, 8'h02, 8'h41);
      cyc(6);
      pd(8'h00, 8'h00, 8'h0d, 8'h0a);
      cyc(6);
      chk_rd(`FSG_REG_STAT, 32'h0004_0000, "tx count");
      chk_tx("copy only");
      pd(8'h00, 8'h04, 8'h43, 8'h44);
      exp = '{8'h02, 8'h41, 8'h0d, 8'h0a};
      chk_tx("send");
      chk_rd(`FSG_REG_STAT, 32'h0, "tx empty");
      stall <= 1'b0;
      for (int k = 0; k < 8; k++) rx(8'h41 + 8'(k));
      cyc(3);
      `CHK("dex", 8'h08, pd_in_o[7:0])
      chk_rd(`FSG_REG_STAT, 32'h0000_0008, "rx count");
      pd(8'h00, 8'h05, 8'h43, 8'h44);
      cyc(12);
      `CHK("block 1", 64'h46454443_4241060a, pd_in_o)
      pd(8'h00, 8'h04, 8'h43, 8'h44);
      cyc(12);
      `CHK("block 2", 64'h00000000_48470200, pd_in_o)
      pd(8'h00, 8'h05, 8'h43, 8'h44);
      cyc(12);
      `CHK("confirm", 64'h0, pd_in_o)
      for (int k = 0; k < 3; k++) rx(8'h61 + 8'(k));
      pd(8'h00, 8'h04, 8'h43, 8'h44);
      cyc(12);
      `CHK("block 3", 64'h00000063_62610302, pd_in_o)
      for (int k = 0; k < 1030; k++) rx(8'h71);
      pd(8'h00, 8'h0c, 8'h51, 8'h52);
      cyc(4);
      chk_rd(`FSG_REG_STAT, 32'h0002_0400, "buffers full");
      pd(8'haa, 8'haa, 8'haa, 8'haa);
      cyc(HOLD + 10);
      `CHK("pattern image", 64'h0, pd_in_o)
      chk_rd(`FSG_REG_STAT, 32'h0, "pattern buf");
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire
